// *** logic/tws_params.svh ***
// Purpose: Constants for the two-wire master-receiver / slave-receiver block
// Assumes: 40 MHz system clock, Wishbone byte addressing
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ============================================================
// Register offsets
`define TWS_OFS_CTRL   8'h00
`define TWS_OFS_STAT   8'h04
`define TWS_OFS_DATA   8'h08
`define TWS_OFS_ADDR   8'h0c
`define TWS_OFS_SLEEP  8'h10

// ============================================================
// Control field positions
`define TWS_CB_IFLAG   7
`define TWS_CB_ACKEN   6
`define TWS_CB_START   5
`define TWS_CB_STOP    4
`define TWS_CB_IFEN    2

// ============================================================
// Reset values
`define TWS_RST_CTRL   8'h00
`define TWS_RST_ADDR   8'h00
`define TWS_RST_DATA   8'hff

// ============================================================
// Status codes
`define TWS_ST_START   8'h08
`define TWS_ST_RSTART  8'h10
`define TWS_ST_ARBL    8'h38
`define TWS_ST_RADK    8'h40
`define TWS_ST_RANK    8'h48
`define TWS_ST_DACK    8'h50
`define TWS_ST_DNAK    8'h58
`define TWS_ST_SOWN    8'h60
`define TWS_ST_SOWNAL  8'h68
`define TWS_ST_SGC     8'h70
`define TWS_ST_SGCAL   8'h78
`define TWS_ST_SDACK   8'h80
`define TWS_ST_SDNAK   8'h88
`define TWS_ST_GDACK   8'h90
`define TWS_ST_GDNAK   8'h98
`define TWS_ST_SSTOP   8'ha0
`define TWS_ST_IDLE    8'hf8

// ============================================================
// Timing: quarter bit of the master clock (100 kHz line)
`define TWS_T_QTR_NS   2500
`define TWS_CLK_NS     25
`define TWS_QTR_CYC    (`TWS_T_QTR_NS / `TWS_CLK_NS)

`endif

// *** logic/tws_pkg.sv ***
// Purpose: Types for the two-wire block
// Assumes: Imported by every design file except tws_sync2
// Notes:   Constants live in tws_params.svh
package tws_pkg;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [7:0] dat;
    } tws_wb_req_t;

    typedef struct packed {
        logic sda;
        logic scl;
    } tws_line_t;

    typedef struct packed {
        logic sda_out;
        logic sda_oe;
        logic scl_out;
        logic scl_oe;
    } tws_drive_t;

endpackage

// *** logic/tws_sync2.sv ***
// Purpose: Two-flop synchroniser for one line input
// Assumes: Input asynchronous to clk_sys
// Notes:   First flop feeds only the second
`timescale 1ns/1ps
module tws_sync2 (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b1;
            q      <= 1'b1;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// *** logic/tws_bus_mon.sv ***
// Purpose: Line condition detector: start, stop, clock edges, busy
// Assumes: Synchronised sda and scl
// Notes:   Pulses are one clk_sys cycle long
`timescale 1ns/1ps
module tws_bus_mon
    import tws_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      rst_n,
    input  wire tws_line_t line,
    output logic           scl_rise,
    output logic           scl_fall,
    output logic           start_seen,
    output logic           stop_seen,
    output logic           busy
);
    tws_line_t prev_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '{sda: 1'b1, scl: 1'b1};
        end else begin
            prev_r <= line;
        end
    end

    assign scl_rise   = line.scl & ~prev_r.scl;
    assign scl_fall   = ~line.scl & prev_r.scl;
    assign start_seen = line.scl & prev_r.scl & prev_r.sda & ~line.sda;
    assign stop_seen  = line.scl & prev_r.scl & ~prev_r.sda & line.sda;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (start_seen) begin
            busy <= 1'b1;
        end else if (stop_seen) begin
            busy <= 1'b0;
        end
    end
endmodule

// *** logic/tws_core.sv ***
// Purpose: Two-wire master receiver and slave receiver with Wishbone registers
// Assumes: 40 MHz clk_sys, lines sampled through two flops
// Notes:   Overview of operation below
// Overview of operation
// - At 0x08 software loads read address, clears flag; device sends it, samples ack
// - At 0x10 read or write address may be loaded; both are sent as at 0x08, with no transmitter
// - Lost arbitration 0x38: release bus; start bit 1 restarts once bus free
// - After 0x40 receive byte, ack per ack enable
// - At 0x48 start/stop select repeated start, stop, or stop then start
// - After 0x50 software reads data; next byte acked per ack enable
// - At 0x58 same three endings as 0x48
// - Stop request bit clears itself when the stop goes out
// - Slave address is own address register bits 7 to 1
// - Own address bit 0 enables general call address 0x00
// - Direction bit 0 gives slave receiver; direction bit 1 is not acknowledged
// - Own address plus write sets flag with valid status
// - Addressed after lost arbitration reports 0x68 or 0x78
// - Ack enable cleared gives not-acknowledge after next data byte
// - Ack enable 0 ignores own address; recognition resumes when set
// - In deep sleep with ack enable, address still acknowledged from bus clock
// - Sleep match wakes part; SCL held low until flag cleared
// - Data register need not hold last bus byte after wake
// - Flag set after each event that loads a new status, except a stop; writing 1 clears it
`timescale 1ns/1ps
module tws_core
    import tws_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire tws_wb_req_t wb_req,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sda_in,
    input  wire logic        scl_in,
    output tws_drive_t       drive,
    output logic             wake_req
);
`include "tws_params.svh"

    // ============================================================
    // Reset release and line sampling
    logic       rst_s1_r, rst_q_n;
    tws_line_t  line;
    logic       scl_rise, scl_fall, start_seen, stop_seen, busy;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_q_n  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_q_n  <= rst_s1_r;
        end
    end

    tws_sync2 u_sda (.clk_sys(clk_sys), .rst_n(rst_q_n), .d(sda_in), .q(line.sda));
    tws_sync2 u_scl (.clk_sys(clk_sys), .rst_n(rst_q_n), .d(scl_in), .q(line.scl));

    tws_bus_mon u_mon (
        .clk_sys   (clk_sys),
        .rst_n     (rst_q_n),
        .line      (line),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_seen(start_seen),
        .stop_seen (stop_seen),
        .busy      (busy)
    );

    // ============================================================
    // Registers
    logic [7:0] ctrl_r, stat_r, data_r, addr_r;
    logic       sleep_r;
    logic       iflag_set, stop_done;
    logic [7:0] shift_r;
    logic       wb_hit, wb_wr;

    assign wb_hit = wb_req.cyc & wb_req.stb & ~wb_ack_o;
    assign wb_wr  = wb_hit & wb_req.we & wb_req.sel[0];

    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0;
            if (wb_hit && !wb_req.we) begin
                unique case (wb_req.adr)
                    `TWS_OFS_CTRL:  wb_dat_o <= {24'h0, ctrl_r};
                    `TWS_OFS_STAT:  wb_dat_o <= {24'h0, stat_r};
                    `TWS_OFS_DATA:  wb_dat_o <= {24'h0, data_r};
                    `TWS_OFS_ADDR:  wb_dat_o <= {24'h0, addr_r};
                    `TWS_OFS_SLEEP: wb_dat_o <= {31'h0, sleep_r};
                    default:        wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Control: flag set by hardware wins over a software clear
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            ctrl_r <= `TWS_RST_CTRL;
        end else begin
            if (wb_wr && wb_req.adr == `TWS_OFS_CTRL) begin
                ctrl_r[6:0] <= wb_req.dat[6:0];
                if (wb_req.dat[`TWS_CB_IFLAG]) begin
                    ctrl_r[`TWS_CB_IFLAG] <= 1'b0;
                end
            end
            if (stop_done) begin
                ctrl_r[`TWS_CB_STOP] <= 1'b0;
            end
            if (iflag_set) begin
                ctrl_r[`TWS_CB_IFLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            addr_r  <= `TWS_RST_ADDR;
            sleep_r <= 1'b0;
        end else if (wb_wr) begin
            if (wb_req.adr == `TWS_OFS_ADDR) begin
                addr_r <= wb_req.dat;
            end
            if (wb_req.adr == `TWS_OFS_SLEEP) begin
                sleep_r <= wb_req.dat[0];
            end
        end
    end

    // ============================================================
    // Engine
    typedef enum logic [3:0] {
        S_IDLE, S_WAIT_FREE, S_START, S_HOLD, S_ADDR, S_MACK, S_MRX, S_MRXACK,
        S_STOP, S_LISTEN, S_SRX, S_SACK, S_SIGNORE
    } tws_state_t;

    tws_state_t  st_r;
    logic [2:0]  bit_r;
    logic [6:0]  qtr_r;
    logic [1:0]  phase_r;
    logic        tick;
    logic        master_r, gcall_r, arb_r, restart_after_r, ack_out_r;
    logic        iflag;
    logic        clear_wr;

    assign iflag    = ctrl_r[`TWS_CB_IFLAG];
    assign clear_wr = wb_wr && wb_req.adr == `TWS_OFS_CTRL && wb_req.dat[`TWS_CB_IFLAG];
    assign tick     = qtr_r == 7'd0;

    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            qtr_r <= 7'(`TWS_QTR_CYC - 1);
        end else if (tick) begin
            qtr_r <= 7'(`TWS_QTR_CYC - 1);
        end else begin
            qtr_r <= qtr_r - 7'd1;
        end
    end

    logic addr_match_own, addr_match_gc;
    assign addr_match_own = shift_r[7:1] == addr_r[7:1];
    assign addr_match_gc  = shift_r[7:1] == 7'h00 && addr_r[0];

    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_r            <= S_IDLE;
            bit_r           <= 3'd7;
            phase_r         <= 2'd0;
            shift_r         <= 8'h0;
            data_r          <= `TWS_RST_DATA;
            stat_r          <= `TWS_ST_IDLE;
            master_r        <= 1'b0;
            gcall_r         <= 1'b0;
            arb_r           <= 1'b0;
            restart_after_r <= 1'b0;
            ack_out_r       <= 1'b0;
            iflag_set       <= 1'b0;
            stop_done       <= 1'b0;
            drive           <= '{sda_out: 1'b0, sda_oe: 1'b0, scl_out: 1'b0, scl_oe: 1'b0};
            wake_req        <= 1'b0;
        end else begin
            iflag_set <= 1'b0;
            stop_done <= 1'b0;
            if (wb_wr && wb_req.adr == `TWS_OFS_DATA && iflag) begin
                data_r <= wb_req.dat;
            end
            if (clear_wr) begin
                wake_req <= 1'b0;
            end
            // Stretch SCL while flag is up, even from sleep wake
            if (iflag && (st_r == S_HOLD || st_r == S_SIGNORE)) begin
                drive.scl_oe <= line.scl ? drive.scl_oe : 1'b1;
            end
            unique case (st_r)
                S_IDLE: begin
                    drive.sda_oe <= 1'b0;
                    drive.scl_oe <= 1'b0;
                    if (ctrl_r[`TWS_CB_IFEN] && !iflag) begin
                        if (ctrl_r[`TWS_CB_START]) begin
                            st_r <= S_WAIT_FREE;
                        end else if (start_seen) begin
                            st_r  <= S_LISTEN;
                            bit_r <= 3'd7;
                        end
                    end
                end
                S_WAIT_FREE: begin
                    if (!busy && tick) begin
                        st_r    <= S_START;
                        phase_r <= 2'd0;
                    end else if (start_seen) begin
                        st_r  <= S_LISTEN;
                        bit_r <= 3'd7;
                    end
                end
                S_START: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        if (phase_r == 2'd0) begin
                            drive.sda_oe <= 1'b1;
                        end else if (phase_r == 2'd1) begin
                            drive.scl_oe <= 1'b1;
                            master_r     <= 1'b1;
                            stat_r       <= restart_after_r || master_r ? `TWS_ST_RSTART : `TWS_ST_START;
                            restart_after_r <= 1'b0;
                            iflag_set    <= 1'b1;
                            st_r         <= S_HOLD;
                        end
                    end
                end
                S_HOLD: begin
                    // Master waits with SCL low for software
                    if (clear_wr) begin
                        if (stat_r == `TWS_ST_START || stat_r == `TWS_ST_RSTART) begin
                            shift_r <= data_r;
                            bit_r   <= 3'd7;
                            phase_r <= 2'd0;
                            st_r    <= S_ADDR;
                        end else if (stat_r == `TWS_ST_RADK || stat_r == `TWS_ST_DACK) begin
                            ack_out_r <= wb_req.dat[`TWS_CB_ACKEN];
                            bit_r     <= 3'd7;
                            phase_r   <= 2'd0;
                            st_r      <= S_MRX;
                        end else if (wb_req.dat[`TWS_CB_STOP]) begin
                            restart_after_r <= wb_req.dat[`TWS_CB_START];
                            phase_r <= 2'd0;
                            st_r    <= S_STOP;
                        end else if (wb_req.dat[`TWS_CB_START]) begin
                            phase_r <= 2'd0;
                            drive.sda_oe <= 1'b0;
                            st_r    <= S_START;
                        end
                    end
                end
                S_ADDR, S_MRX: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        unique case (phase_r)
                            2'd0: drive.sda_oe <= st_r == S_ADDR ? ~shift_r[7] : 1'b0;
                            2'd1: drive.scl_oe <= 1'b0;
                            2'd2: begin
                                if (st_r == S_ADDR && shift_r[7] && !line.sda) begin
                                    arb_r        <= 1'b1;
                                    drive.scl_oe <= 1'b0;
                                    drive.sda_oe <= 1'b0;
                                    master_r     <= 1'b0;
                                    stat_r       <= `TWS_ST_ARBL;
                                    iflag_set    <= 1'b1;
                                    st_r         <= S_SIGNORE;
                                end
                                shift_r <= {shift_r[6:0], line.sda};
                            end
                            2'd3: begin
                                drive.scl_oe <= 1'b1;
                                bit_r <= bit_r - 3'd1;
                                if (bit_r == 3'd0) begin
                                    st_r <= st_r == S_ADDR ? S_MACK : S_MRXACK;
                                end
                            end
                        endcase
                    end
                end
                S_MACK, S_MRXACK: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        unique case (phase_r)
                            2'd0: drive.sda_oe <= st_r == S_MRXACK ? ack_out_r : 1'b0;
                            2'd1: drive.scl_oe <= 1'b0;
                            2'd2: begin
                                if (st_r == S_MACK) begin
                                    // Address ack sampled; read and write addresses both stay receiver
                                    stat_r <= line.sda ? `TWS_ST_RANK : `TWS_ST_RADK;
                                end else begin
                                    data_r <= shift_r;
                                    stat_r <= ack_out_r ? `TWS_ST_DACK : `TWS_ST_DNAK;
                                end
                            end
                            2'd3: begin
                                drive.scl_oe <= 1'b1;
                                drive.sda_oe <= 1'b0;
                                iflag_set    <= 1'b1;
                                st_r         <= S_HOLD;
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        unique case (phase_r)
                            2'd0: drive.sda_oe <= 1'b1;
                            2'd1: drive.scl_oe <= 1'b0;
                            2'd2: drive.sda_oe <= 1'b0;
                            2'd3: begin
                                stop_done <= 1'b1;
                                master_r  <= 1'b0;
                                stat_r    <= `TWS_ST_IDLE;
                                st_r      <= restart_after_r ? S_WAIT_FREE : S_IDLE;
                            end
                        endcase
                    end
                end
                S_LISTEN: begin
                    if (stop_seen) begin
                        st_r <= S_IDLE;
                    end else if (scl_rise) begin
                        shift_r <= {shift_r[6:0], line.sda};
                        bit_r   <= bit_r - 3'd1;
                        if (bit_r == 3'd0) begin
                            st_r <= S_SACK;
                        end
                    end
                end
                S_SACK: begin
                    // Address byte complete, decide the ninth bit
                    if (scl_fall) begin
                        if (ctrl_r[`TWS_CB_ACKEN] && !iflag &&
                            (addr_match_own || addr_match_gc) && !shift_r[0]) begin
                            drive.sda_oe <= 1'b1;
                            gcall_r      <= ~addr_match_own;
                            stat_r       <= addr_match_own ? (arb_r ? `TWS_ST_SOWNAL : `TWS_ST_SOWN)
                                                            : (arb_r ? `TWS_ST_SGCAL : `TWS_ST_SGC);
                            wake_req     <= sleep_r;
                            st_r         <= S_SIGNORE;
                        end else begin
                            st_r <= S_SIGNORE;
                        end
                        arb_r <= 1'b0;
                    end
                end
                S_SIGNORE: begin
                    if (stop_seen) begin
                        drive.sda_oe <= 1'b0;
                        drive.scl_oe <= 1'b0;
                        st_r         <= S_IDLE;
                    end else if (scl_fall && drive.sda_oe) begin
                        drive.sda_oe <= 1'b0;
                        iflag_set    <= 1'b1;
                    end else if (clear_wr && drive.scl_oe) begin
                        drive.scl_oe <= 1'b0;
                        st_r         <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ============================================================
    // Checks
    chk_stop_clears: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        stop_done |=> !ctrl_r[`TWS_CB_STOP])
        else $error("stop request not cleared");
    chk_flag_sets: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        iflag_set |=> iflag)
        else $error("flag not set");
    chk_start_hold: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        (st_r == S_HOLD && iflag && !clear_wr) |=> st_r == S_HOLD)
        else $error("bus action while flag set");
    chk_wb_ack: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_nack_sel: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        (st_r == S_MRXACK && phase_r == 2'd1 && tick) |-> (drive.sda_oe == ack_out_r))
        else $error("ack bit wrong");
    chk_no_ack_off: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        (st_r == S_SACK && scl_fall && !ctrl_r[`TWS_CB_ACKEN]) |=> !drive.sda_oe)
        else $error("acked with ack enable off");
    chk_gc_gate: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        (st_r == S_SACK && scl_fall && !addr_match_own && !addr_r[0]) |=> !drive.sda_oe)
        else $error("general call acked while disabled");
    chk_wake_hold: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
        (wake_req && !clear_wr) |=> wake_req)
        else $error("wake dropped early");
endmodule

// *** test/tws_rmt_master.sv ***
// Purpose: Remote two-wire master that sends one address byte
// Assumes: Open-drain lines with pull-ups resolved in the bench
// Notes:   Bit period 200 ns; waits while SCL is stretched
`timescale 1ns/1ps
module tws_rmt_master (
    input  wire logic sda_line,
    input  wire logic scl_line,
    output logic      sda_o,
    output logic      scl_o
);
    initial begin
        sda_o = 1'b1;
        scl_o = 1'b1;
    end
    task automatic clk_bit(input logic b, output logic s);
        #50 sda_o = b;
        #50 scl_o = 1'b1;
        wait (scl_line === 1'b1);
        #100 s = sda_line;
        scl_o = 1'b0;
    endtask
    task automatic frame(input logic [7:0] b, output logic ack);
        logic s;
        sda_o = 1'b0;
        #100 scl_o = 1'b0;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic stop();
        #50 sda_o = 1'b0;
        #50 scl_o = 1'b1;
        wait (scl_line === 1'b1);
        #100 sda_o = 1'b1;
        #200 sda_o = 1'b1;
    endtask
endmodule

// *** test/tws_core_test.sv ***
// Purpose: Self-checking bench for slave address handling and registers
// Assumes: Remote master model on the lines, Wishbone master tasks
// Notes:   Read results are checked by a monitor from a queue
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_core_test
    import tws_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    tws_wb_req_t wb_req = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, wake_req, m_sda, m_scl, ack;
    tws_drive_t  drive;
    wire         sda = m_sda & ~drive.sda_oe;
    wire         scl = m_scl & ~drive.scl_oe;
    int          errors = 0;
    int          checks_done = 0;
    logic [15:0] exp_q[$];
    logic [6:0]  adr;
    always #12.5 clk_sys = ~clk_sys;
    tws_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sda_in(sda), .scl_in(scl), .drive(drive), .wake_req(wake_req));
    tws_rmt_master rm (.sda_line(sda), .scl_line(scl), .sda_o(m_sda), .scl_o(m_scl));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wb_req <= '{1'b1, 1'b1, we, a, 4'h1, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        wb_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e});
        wb(1'b0, a, 8'h00);
    endtask
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
            chk(wb_dat_o & {24'h0, exp_q[0][15:8]}, {24'h0, exp_q[0][7:0]});
            void'(exp_q.pop_front());
        end
    end
    task automatic addr_hit(input logic [7:0] b, input logic [7:0] st, input logic wk);
        logic a;
        rm.frame(b, a);
        chk(a, 1'b1);
        for (int i = 0; i < 400 && drive.scl_oe !== 1'b1; i++) @(posedge clk_sys);
        rd(`TWS_OFS_STAT, st, 8'hf8);
        rd(`TWS_OFS_CTRL, 8'h80, 8'h80);
        chk(scl, 1'b0);
        chk(wake_req, wk);
        wb(1'b1, `TWS_OFS_CTRL, 8'hc4);
        rm.stop();
        chk(wake_req, 1'b0);
    endtask
    task automatic final_report();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h335a));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(`TWS_OFS_CTRL, `TWS_RST_CTRL, 8'hff);
        rd(`TWS_OFS_ADDR, `TWS_RST_ADDR, 8'hff);
        rd(8'h40, 8'h00, 8'hff);
        adr = 7'($urandom_range(1, 127));
        wb(1'b1, `TWS_OFS_ADDR, {adr, 1'b1});
        rd(`TWS_OFS_ADDR, {adr, 1'b1}, 8'hff);
        wb(1'b1, `TWS_OFS_CTRL, 8'h44);
        addr_hit({adr, 1'b0}, `TWS_ST_SOWN, 1'b0);
        addr_hit(8'h00, `TWS_ST_SGC, 1'b0);
        wb(1'b1, `TWS_OFS_CTRL, 8'h04);
        rm.frame({adr, 1'b0}, ack);
        chk(ack, 1'b0);
        rm.stop();
        wb(1'b1, `TWS_OFS_ADDR, {adr, 1'b0});
        wb(1'b1, `TWS_OFS_CTRL, 8'h44);
        rm.frame(8'h00, ack);
        chk(ack, 1'b0);
        rm.stop();
        wb(1'b1, `TWS_OFS_SLEEP, 8'h01);
        addr_hit({adr, 1'b0}, `TWS_ST_SOWN, 1'b1);
        wb(1'b1, `TWS_OFS_SLEEP, 8'h00);
        wb(1'b1, `TWS_OFS_CTRL, 8'ha4);
        repeat (400) @(posedge clk_sys);
        rd(`TWS_OFS_STAT, `TWS_ST_START, 8'hf8);
        wb(1'b1, `TWS_OFS_DATA, {adr, 1'b1});
        wb(1'b1, `TWS_OFS_CTRL, 8'h84);
        repeat (4000) @(posedge clk_sys);
        rd(`TWS_OFS_STAT, `TWS_ST_RANK, 8'hf8);
        rd(`TWS_OFS_CTRL, 8'h80, 8'h80);
        wb(1'b1, `TWS_OFS_CTRL, 8'h94);
        repeat (600) @(posedge clk_sys);
        rd(`TWS_OFS_CTRL, 8'h00, 8'h90);
        rd(`TWS_OFS_STAT, `TWS_ST_IDLE, 8'hf8);
        final_report();
    end
    initial begin
        #400us;
        errors++;
        final_report();
    end
endmodule
